//--- core/pol_pkg.sv
// Shared constants for the load converter and its power manager.
// What this block does
// RULE1: Bit 5 picks 500 kHz or 1000 kHz.
// RULE2: Interleave register changes only while output off.
// RULE3: Manager clocks line; converter locks onto it.
// RULE4: Switching aligns to line falling edge.
// RULE5: Frequency choice is per converter, still synced.
// RULE6: PWM start delayed after falling edge by phase.
// RULE7: Bits 3:0 give lag in 22.5 degree steps.
// RULE8: Bits 7:6 pick which phase outputs run.
// RULE9: Bit 4 of interleave register reads zero.
// RULE10: Bits 7:2 cap duty at code/64; low bits zero.
// RULE11: Controller trims duty around nominal to hold set point.
// RULE12: PID plus roll-off, each coefficient its own register.
// RULE13: Inject noise into PWM, capture output voltage response.
// RULE14: Voltage reading 12 bits, current and temperature 8.
// RULE15: Current reading corrected using temperature reading.
// RULE16: Manager refreshes reading copies every second.
// RULE17: Line frames take priority; host requests held meanwhile.
// RULE18: Host timeout should exceed polling time and 150 ms.
// RULE19: No load current sharing logic.
// RULE20: On-time never exceeds duty cap fraction of period.
// RULE21: Interleave writes while output enabled are ignored.
package pol_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SYNC_PERIOD_NS = 2000;
  localparam int SYNC_HALF_CYC  = SYNC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int REFRESH_MS     = 1000;
  localparam int REFRESH_CYC    = REFRESH_MS * 100000;
  localparam int HOST_TIMEOUT_MS = 150;

  localparam int ADDR_W     = 5;
  localparam int FRAME_DATA = 7;
  localparam int FRAME_END  = 15;

  localparam logic [4:0] ADDR_INTERLEAVE = 5'h04;
  localparam logic [4:0] ADDR_DUTY_LIMIT = 5'h09;
  localparam logic [4:0] ADDR_PROP_COEF  = 5'h0a;
  localparam logic [4:0] ADDR_INTEG_COEF = 5'h0b;
  localparam logic [4:0] ADDR_DERIV_COEF = 5'h0c;
  localparam logic [4:0] ADDR_ROLL_COEF  = 5'h0d;
  localparam logic [4:0] ADDR_VOUT_HI    = 5'h0e;
  localparam logic [4:0] ADDR_VOUT_LO    = 5'h0f;
  localparam logic [4:0] ADDR_IOUT       = 5'h10;
  localparam logic [4:0] ADDR_TEMP       = 5'h11;
  localparam logic [4:0] ADDR_PROBE_CTRL = 5'h12;
  localparam logic [4:0] ADDR_PROBE_DATA = 5'h13;

  localparam int FRQ_BIT = 5;
  localparam int PHS_LSB = 6;
  localparam int INT_LSB = 0;
  localparam int DCL_LSB = 2;

  localparam logic [7:0] INTERLEAVE_RST   = 8'h00;
  localparam logic [7:0] INTERLEAVE_WMASK = 8'hef;
  localparam logic [7:0] DUTY_LIMIT_RST   = 8'he4;
  localparam logic [7:0] DUTY_LIMIT_WMASK = 8'hfc;
  localparam logic [7:0] PROP_COEF_RST    = 8'h20;
  localparam logic [7:0] INTEG_COEF_RST   = 8'h04;
  localparam logic [7:0] DERIV_COEF_RST   = 8'h10;
  localparam logic [7:0] ROLL_COEF_RST    = 8'h80;
  localparam logic [7:0] TEMP_REF         = 8'h40;
  localparam logic [7:0] LFSR_SEED        = 8'h5a;
  localparam int         INTEG_LIMIT      = 1048576;
endpackage

//--- core/pol_link_if.sv
// Sync/communication line between power manager and load converter.
`timescale 1ns/10ps
interface pol_link_if;
  logic sync_comm_line;
  logic mgr_dat_out;
  logic mgr_dat_oe_n;
  logic dev_dat_out;
  logic dev_dat_oe_n;
  logic dat;

  // Open-drain data wire with pull-up: any enabled low driver wins
  assign dat = (mgr_dat_oe_n | mgr_dat_out) & (dev_dat_oe_n | dev_dat_out);

  modport manager (output sync_comm_line, output mgr_dat_out,
                   output mgr_dat_oe_n, input dat);
  modport device  (input sync_comm_line, input dat,
                   output dev_dat_out, output dev_dat_oe_n);
endinterface

//--- core/pol_load_conv.sv
// Load converter end: line slave, registers, PWM timing and PID.
`timescale 1ns/10ps
module pol_load_conv
  import pol_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  pol_link_if.device       link,
  input  wire logic        OUT_EN_IN,
  input  wire logic [11:0] VOUT_SET_IN,
  input  wire logic [11:0] VOUT_ADC_IN,
  input  wire logic [7:0]  IOUT_ADC_IN,
  input  wire logic [7:0]  TEMP_ADC_IN,
  output logic      [3:0]  PHASE_OUT_OUT,
  output logic             SYNC_LOCK_OUT
);
  typedef enum logic [2:0] {S_IDLE, S_RW, S_ADDR, S_WDATA, S_RDATA} pol_slv_t;

  logic        sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic        dat_s1_reg, dat_s2_reg;
  logic        fall;
  logic [15:0] per_cnt_reg, sync_per_reg, ph_cnt_reg, pwm_cnt_reg;
  logic [15:0] sw_per, delay, cap_cyc, on_time_reg;
  logic [1:0]  falls_reg;
  logic        start;
  logic [7:0]  interleave_reg, duty_limit_reg;
  logic [7:0]  prop_gain_coef, integral_coef, deriv_coef;
  logic [7:0]  deriv_rolloff_coef, probe_data_reg, lfsr_reg;
  logic        probe_en_reg;
  logic [11:0] vout_reading;
  logic [7:0]  iout_reading, temp_reading;
  logic        switch_freq_select;
  logic [1:0]  phase_count_select;
  logic [3:0]  phase_code;
  logic [5:0]  duty_cap_code;
  logic [3:0]  phase_active;
  pol_slv_t    slv_reg;
  logic        rw_reg;
  logic [4:0]  addr_reg;
  logic [7:0]  shift_reg, rd_val, shift_next;
  logic [2:0]  bit_cnt_reg;
  logic        wr_commit;
  logic signed [13:0] err_prev_reg;
  logic signed [23:0] deriv_reg;
  logic signed [21:0] integ_reg;
  int          err, derr, d_next, i_next, u, duty, noise, cap_i;
  int          icorr;

  assign switch_freq_select = interleave_reg[FRQ_BIT];
  assign phase_count_select = interleave_reg[PHS_LSB +: 2];
  assign phase_code         = interleave_reg[INT_LSB +: 4];
  assign duty_cap_code      = duty_limit_reg[DCL_LSB +: 6];

  // Line inputs come from another domain: two stages before use
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_s3_reg <= 1'b1;
      dat_s1_reg  <= 1'b1;
      dat_s2_reg  <= 1'b1;
    end else begin
      sclk_s1_reg <= link.sync_comm_line;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      dat_s1_reg  <= link.dat;
      dat_s2_reg  <= dat_s1_reg;
    end
  end
  assign fall = sclk_s3_reg & ~sclk_s2_reg; // see RULE4

  // Period tracker stands in for the PLL: lock after two falling edges
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      per_cnt_reg   <= 16'h0000;
      sync_per_reg  <= 16'h00c8;
      falls_reg     <= 2'h0;
      SYNC_LOCK_OUT <= 1'b0;
    end else if (fall) begin
      per_cnt_reg   <= 16'h0000;
      sync_per_reg  <= per_cnt_reg + 16'h0001; // see RULE3
      if (falls_reg != 2'h3)
        falls_reg <= falls_reg + 2'h1;
      SYNC_LOCK_OUT <= (falls_reg >= 2'h1);
    end else if (per_cnt_reg != 16'hffff) begin
      per_cnt_reg <= per_cnt_reg + 16'h0001;
    end
  end

  // Each converter keeps its own frequency on the common line
  assign sw_per = switch_freq_select ? {1'b0, sync_per_reg[15:1]}
                                     : sync_per_reg; // see RULE1, RULE5
  // code * 22.5 degrees is code/16 of the switching period
  assign delay   = 16'((32'(sw_per) * 32'(phase_code)) >> 4); // see RULE7
  assign cap_cyc = 16'((32'(sw_per) * 32'(duty_cap_code)) >> 6);
  assign start = SYNC_LOCK_OUT &&
                 ((ph_cnt_reg == delay) ||
                  (switch_freq_select &&
                   ph_cnt_reg == delay + sw_per)); // see RULE6

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ph_cnt_reg  <= 16'h0000;
      pwm_cnt_reg <= 16'h0000;
    end else begin
      ph_cnt_reg <= fall ? 16'h0000 : ph_cnt_reg + 16'h0001;
      if (start)
        pwm_cnt_reg <= 16'h0000;
      else if (pwm_cnt_reg != 16'hffff)
        pwm_cnt_reg <= pwm_cnt_reg + 16'h0001;
    end
  end

  always_comb begin
    case (phase_count_select) // see RULE8
      2'h0:    phase_active = 4'b0001;
      2'h1:    phase_active = 4'b0101;
      2'h2:    phase_active = 4'b0111;
      default: phase_active = 4'b1111;
    endcase
  end

  // Outputs sit a quarter period apart; phases stay low when disabled
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_phase
      logic [16:0] offs;
      logic [16:0] wrapped;
      assign offs = {1'b0, pwm_cnt_reg} +
                    17'((32'(sw_per) * k) >> 2);
      assign wrapped = (offs >= {1'b0, sw_per}) ? offs - {1'b0, sw_per}
                                                : offs;
      always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN)
          PHASE_OUT_OUT[k] <= 1'b0;
        else
          PHASE_OUT_OUT[k] <= OUT_EN_IN && SYNC_LOCK_OUT &&
                              phase_active[k] &&
                              (wrapped < {1'b0, on_time_reg});
      end
    end
  endgenerate

  // Controller: the integrator carries the nominal duty, the other terms
  // trim it; roll-off is a first-order filter on the derivative term
  always_comb begin
    err    = int'(VOUT_SET_IN) - int'(vout_reading);
    derr   = err - int'(err_prev_reg);
    d_next = ((int'(deriv_reg) * int'(deriv_rolloff_coef)) >>> 8) +
             int'(deriv_coef) * derr; // see RULE12
    i_next = int'(integ_reg) + int'(integral_coef) * err;
    if (i_next > INTEG_LIMIT - 1)
      i_next = INTEG_LIMIT - 1;
    if (i_next < -INTEG_LIMIT)
      i_next = -INTEG_LIMIT;
    u      = int'(prop_gain_coef) * err + (i_next >>> 4) + d_next;
    noise  = probe_en_reg ? int'(lfsr_reg[3:0]) - 8 : 0; // see RULE13
    duty   = (u >>> 6) + noise; // see RULE11
    cap_i  = int'(cap_cyc);
    if (duty > cap_i)
      duty = cap_i; // see RULE20
    if (duty < 0)
      duty = 0;
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      on_time_reg  <= 16'h0000;
      err_prev_reg <= 14'sh0000;
      deriv_reg    <= 24'sh000000;
      integ_reg    <= 22'sh000000;
    end else if (start) begin
      on_time_reg  <= 16'(duty);
      err_prev_reg <= 14'(err);
      deriv_reg    <= 24'(d_next);
      integ_reg    <= OUT_EN_IN ? 22'(i_next) : 22'sh000000;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      lfsr_reg       <= LFSR_SEED;
      probe_data_reg <= 8'h00;
    end else if (start && probe_en_reg) begin
      lfsr_reg <= {lfsr_reg[6:0],
                   lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      probe_data_reg <= vout_reading[11:4]; // see RULE13
    end
  end

  // Temperature above the reference raises the inductor resistance
  always_comb begin
    icorr = (int'(IOUT_ADC_IN) * 256) /
            (256 + int'(TEMP_ADC_IN) - int'(TEMP_REF)); // see RULE15
    if (icorr > 255)
      icorr = 255;
  end

  // Readings refresh every cycle; no current-sharing path exists
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      vout_reading <= 12'h000;
      iout_reading <= 8'h00;
      temp_reading <= 8'h00;
    end else begin
      vout_reading <= VOUT_ADC_IN; // see RULE14
      iout_reading <= 8'(icorr);
      temp_reading <= TEMP_ADC_IN; // see RULE19
    end
  end

  // Line slave: samples at falling edges, drives read bits after them
  assign shift_next = {shift_reg[6:0], dat_s2_reg};
  assign wr_commit  = fall && slv_reg == S_WDATA && bit_cnt_reg == 3'h7;

  // Decoded while the last address bit is still arriving on the line
  always_comb begin
    case ({addr_reg[3:0], dat_s2_reg})
      ADDR_INTERLEAVE: rd_val = interleave_reg & INTERLEAVE_WMASK; // see RULE9
      ADDR_DUTY_LIMIT: rd_val = duty_limit_reg & DUTY_LIMIT_WMASK; // see RULE10
      ADDR_PROP_COEF:  rd_val = prop_gain_coef;
      ADDR_INTEG_COEF: rd_val = integral_coef;
      ADDR_DERIV_COEF: rd_val = deriv_coef;
      ADDR_ROLL_COEF:  rd_val = deriv_rolloff_coef;
      ADDR_VOUT_HI:    rd_val = {4'h0, vout_reading[11:8]};
      ADDR_VOUT_LO:    rd_val = vout_reading[7:0];
      ADDR_IOUT:       rd_val = iout_reading;
      ADDR_TEMP:       rd_val = temp_reading;
      ADDR_PROBE_CTRL: rd_val = {7'h00, probe_en_reg};
      ADDR_PROBE_DATA: rd_val = probe_data_reg;
      default:         rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      slv_reg          <= S_IDLE;
      rw_reg           <= 1'b0;
      addr_reg         <= 5'h00;
      shift_reg        <= 8'h00;
      bit_cnt_reg      <= 3'h0;
      link.dev_dat_out  <= 1'b1;
      link.dev_dat_oe_n <= 1'b1;
    end else if (fall) begin
      case (slv_reg)
        S_IDLE: begin
          if (!dat_s2_reg)
            slv_reg <= S_RW;
        end
        S_RW: begin
          rw_reg      <= dat_s2_reg;
          bit_cnt_reg <= 3'h0;
          slv_reg     <= S_ADDR;
        end
        S_ADDR: begin
          addr_reg    <= {addr_reg[3:0], dat_s2_reg};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h4) begin
            bit_cnt_reg <= 3'h0;
            slv_reg     <= rw_reg ? S_RDATA : S_WDATA;
          end
        end
        S_WDATA: begin
          shift_reg   <= shift_next;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
            slv_reg <= S_IDLE;
        end
        S_RDATA: begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7) begin
            link.dev_dat_out  <= 1'b1;
            link.dev_dat_oe_n <= 1'b1;
            slv_reg           <= S_IDLE;
          end
        end
        default: slv_reg <= S_IDLE;
      endcase
      // Read word is latched when the last address bit lands
      if (slv_reg == S_ADDR && bit_cnt_reg == 3'h4 && rw_reg) begin
        shift_reg         <= {rd_val[6:0], 1'b0};
        link.dev_dat_out  <= rd_val[7];
        link.dev_dat_oe_n <= 1'b0;
      end else if (slv_reg == S_RDATA && bit_cnt_reg != 3'h7) begin
        shift_reg        <= {shift_reg[6:0], 1'b0};
        link.dev_dat_out <= shift_reg[7];
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      interleave_reg     <= INTERLEAVE_RST;
      duty_limit_reg     <= DUTY_LIMIT_RST;
      prop_gain_coef     <= PROP_COEF_RST;
      integral_coef      <= INTEG_COEF_RST;
      deriv_coef         <= DERIV_COEF_RST;
      deriv_rolloff_coef <= ROLL_COEF_RST;
      probe_en_reg       <= 1'b0;
    end else if (wr_commit) begin
      case (addr_reg)
        ADDR_INTERLEAVE: begin
          if (!OUT_EN_IN) // see RULE2, RULE21
            interleave_reg <= shift_next & INTERLEAVE_WMASK;
        end
        ADDR_DUTY_LIMIT: duty_limit_reg <= shift_next & DUTY_LIMIT_WMASK;
        ADDR_PROP_COEF:  prop_gain_coef <= shift_next;
        ADDR_INTEG_COEF: integral_coef <= shift_next;
        ADDR_DERIV_COEF: deriv_coef <= shift_next;
        ADDR_ROLL_COEF:  deriv_rolloff_coef <= shift_next;
        ADDR_PROBE_CTRL: probe_en_reg <= shift_next[0];
        default: ;
      endcase
    end
  end
endmodule

//--- core/pol_power_manager.sv
// Power manager end: line clock, frame master, polling and host port.
`timescale 1ns/10ps
module pol_power_manager
  import pol_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC
)(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  pol_link_if.manager      link,
  input  wire logic        REQ_VALID_IN,
  input  wire logic        REQ_WRITE_IN,
  input  wire logic [4:0]  REQ_ADDR_IN,
  input  wire logic [7:0]  REQ_WDATA_IN,
  output logic             REQ_READY_OUT,
  output logic             RSP_VALID_OUT,
  output logic      [7:0]  RSP_RDATA_OUT,
  output logic      [11:0] VOUT_COPY_OUT,
  output logic      [7:0]  IOUT_COPY_OUT,
  output logic      [7:0]  TEMP_COPY_OUT
);
  logic [7:0]  half_cnt_reg;
  logic        toggle, rise, fall_tick;
  logic        dat_s1_reg, dat_s2_reg;
  logic [31:0] refresh_cnt_reg;
  logic        poll_pend_reg, host_pend_reg, busy_reg, cur_poll_reg;
  logic [1:0]  poll_idx_reg;
  logic [3:0]  bit_idx_reg;
  logic [13:0] frame_reg;
  logic        cur_write_reg, take;
  logic [7:0]  rdata_reg, rd_done;
  logic        host_write_reg;
  logic [4:0]  host_addr_reg, poll_addr;
  logic [7:0]  host_wdata_reg;

  assign toggle = (half_cnt_reg == 8'(SYNC_HALF_CYC - 1));
  assign rise   = toggle && !link.sync_comm_line;
  assign fall_tick = toggle && link.sync_comm_line;
  assign take   = REQ_VALID_IN && REQ_READY_OUT;

  // Line clock is a divided copy of the core clock
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      half_cnt_reg        <= 8'h00;
      link.sync_comm_line <= 1'b1;
    end else begin
      half_cnt_reg <= toggle ? 8'h00 : half_cnt_reg + 8'h01;
      if (toggle)
        link.sync_comm_line <= ~link.sync_comm_line; // see RULE3
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dat_s1_reg <= 1'b1;
      dat_s2_reg <= 1'b1;
    end else begin
      dat_s1_reg <= link.dat;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  always_comb begin
    case (poll_idx_reg)
      2'h0:    poll_addr = ADDR_VOUT_HI;
      2'h1:    poll_addr = ADDR_VOUT_LO;
      2'h2:    poll_addr = ADDR_IOUT;
      default: poll_addr = ADDR_TEMP;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      refresh_cnt_reg <= 32'h0;
    else if (refresh_cnt_reg == 32'(REFRESH_CYCLES - 1))
      refresh_cnt_reg <= 32'h0;
    else
      refresh_cnt_reg <= refresh_cnt_reg + 32'h1;
  end

  // A request is held off while a frame or a poll is outstanding; host
  // software should keep its timeout above HOST_TIMEOUT_MS (see RULE18)
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      REQ_READY_OUT  <= 1'b0;
      host_pend_reg  <= 1'b0;
      host_write_reg <= 1'b0;
      host_addr_reg  <= 5'h00;
      host_wdata_reg <= 8'h00;
    end else begin
      REQ_READY_OUT <= !busy_reg && !poll_pend_reg && !host_pend_reg &&
                       !take; // see RULE17
      if (take) begin
        host_pend_reg  <= 1'b1;
        host_write_reg <= REQ_WRITE_IN;
        host_addr_reg  <= REQ_ADDR_IN;
        host_wdata_reg <= REQ_WDATA_IN;
      end else if (rise && !busy_reg && !poll_pend_reg) begin
        host_pend_reg <= 1'b0;
      end
    end
  end

  assign rd_done = {rdata_reg[6:0], dat_s2_reg};

  // Frame: start 0, rw, 5 address bits, 8 data bits, MSB first; bits
  // change on rising line edges and are sampled at the falling ones
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      busy_reg          <= 1'b0;
      cur_poll_reg      <= 1'b0;
      cur_write_reg     <= 1'b0;
      bit_idx_reg       <= 4'h0;
      frame_reg         <= 14'h0;
      rdata_reg         <= 8'h00;
      poll_pend_reg     <= 1'b0;
      poll_idx_reg      <= 2'h0;
      link.mgr_dat_out  <= 1'b1;
      link.mgr_dat_oe_n <= 1'b1;
      RSP_VALID_OUT     <= 1'b0;
      RSP_RDATA_OUT     <= 8'h00;
      VOUT_COPY_OUT     <= 12'h000;
      IOUT_COPY_OUT     <= 8'h00;
      TEMP_COPY_OUT     <= 8'h00;
    end else begin
      RSP_VALID_OUT <= 1'b0;
      if (rise && !busy_reg && (poll_pend_reg || host_pend_reg)) begin
        busy_reg          <= 1'b1;
        cur_poll_reg      <= poll_pend_reg;
        cur_write_reg     <= !poll_pend_reg && host_write_reg;
        frame_reg         <= poll_pend_reg ?
                             {1'b1, poll_addr, 8'h00} :
                             {host_write_reg ? 1'b0 : 1'b1,
                              host_addr_reg, host_wdata_reg};
        bit_idx_reg       <= 4'h1;
        link.mgr_dat_out  <= 1'b0;
        link.mgr_dat_oe_n <= 1'b0;
      end else if (rise && busy_reg) begin
        bit_idx_reg <= bit_idx_reg + 4'h1;
        frame_reg   <= {frame_reg[12:0], 1'b0};
        if (bit_idx_reg < 4'(FRAME_DATA) || cur_write_reg) begin
          link.mgr_dat_out  <= frame_reg[13];
          link.mgr_dat_oe_n <= 1'b0;
        end else begin
          link.mgr_dat_out  <= 1'b1;
          link.mgr_dat_oe_n <= 1'b1;
        end
        if (bit_idx_reg == 4'(FRAME_END)) begin
          busy_reg          <= 1'b0;
          link.mgr_dat_out  <= 1'b1;
          link.mgr_dat_oe_n <= 1'b1;
          if (cur_poll_reg) begin
            case (poll_idx_reg)
              2'h0:    VOUT_COPY_OUT[11:8] <= rdata_reg[3:0];
              2'h1:    VOUT_COPY_OUT[7:0]  <= rdata_reg;
              2'h2:    IOUT_COPY_OUT <= rdata_reg;
              default: TEMP_COPY_OUT <= rdata_reg;
            endcase
            poll_idx_reg <= poll_idx_reg + 2'h1;
            if (poll_idx_reg == 2'h3)
              poll_pend_reg <= 1'b0;
          end else begin
            RSP_VALID_OUT <= 1'b1;
            RSP_RDATA_OUT <= cur_write_reg ? 8'h00 : rdata_reg;
          end
        end
      end
      // Read bits are taken just before the line falls: at the rise the
      // last address bit may still hold the wire low
      if (fall_tick && busy_reg && !cur_write_reg &&
          bit_idx_reg > 4'(FRAME_DATA))
        rdata_reg <= rd_done;
      // A refresh wins over a poll that finishes in the same cycle
      if (refresh_cnt_reg == 32'(REFRESH_CYCLES - 1)) begin
        poll_pend_reg <= 1'b1; // see RULE16
        poll_idx_reg  <= 2'h0;
      end
    end
  end
endmodule

//--- testbench/pol_link_assertions.sv
// Assertions on the manager/converter line signals.
`timescale 1ns/10ps
module pol_link_assertions
  import pol_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic sync_comm_line,
  input wire logic mgr_dat_out,
  input wire logic mgr_dat_oe_n,
  input wire logic dev_dat_out,
  input wire logic dev_dat_oe_n,
  input wire logic dat
);
  logic [15:0] half_cnt_reg;
  logic        sync_q_reg;
  logic        seen_reg;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  // First edge after reset only arms the count, its distance is unknown
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      half_cnt_reg <= 16'h0000;
      sync_q_reg   <= 1'b1;
      seen_reg     <= 1'b0;
    end else begin
      sync_q_reg <= sync_comm_line;
      if (sync_comm_line != sync_q_reg) begin
        half_cnt_reg <= 16'h0000;
        seen_reg     <= 1'b1;
      end else begin
        half_cnt_reg <= half_cnt_reg + 16'h0001;
      end
    end
  end

  sync_half_a: assert property (
    (sync_comm_line != sync_q_reg) && seen_reg
      |-> half_cnt_reg == 16'(SYNC_HALF_CYC - 1))
    else $error("line half period wrong");
  mgr_on_rise_a: assert property (
    ($changed(mgr_dat_oe_n) || $changed(mgr_dat_out)) |-> sync_comm_line)
    else $error("manager data moved in low phase");
  dev_on_fall_a: assert property (
    ($changed(dev_dat_oe_n) || $changed(dev_dat_out)) |-> !sync_comm_line)
    else $error("converter data moved in high phase");
  start_low_a: assert property (
    $fell(mgr_dat_oe_n) |-> !mgr_dat_out ##1 !mgr_dat_oe_n [*8])
    else $error("start bit not held low");
  mgr_bit_hold_a: assert property (
    $changed(mgr_dat_out) |=> $stable(mgr_dat_out) [*8])
    else $error("manager bit too short");
  dev_bit_hold_a: assert property (
    $changed(dev_dat_out) |=> $stable(dev_dat_out) [*8])
    else $error("converter bit too short");
  mgr_idle_a: assert property (
    $rose(mgr_dat_oe_n) |=> mgr_dat_oe_n [*8])
    else $error("manager release too short");
  wire_pull_a: assert property (
    !dat |-> (!mgr_dat_oe_n && !mgr_dat_out) ||
             (!dev_dat_oe_n && !dev_dat_out))
    else $error("data wire low with no driver");
endmodule

//--- testbench/tb_top.sv
// Bench joining power manager and load converter over the line.
`timescale 1ns/10ps
module tb_top import pol_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        out_en = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [4:0]  req_addr = 5'h00;
  logic [7:0]  req_wdata = 8'h00;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_rdata;
  logic [11:0] vout_copy;
  logic [7:0]  iout_copy;
  logic [7:0]  temp_copy;
  logic [3:0]  phase_out;
  logic        sync_lock;
  logic [3:0]  seen;
  logic [3:0]  masks [4] = '{4'h1, 4'h5, 4'h7, 4'hf};
  int          fail_count = 0;
  int          checks = 0;

  initial forever #5 clk = ~clk;

  pol_link_if i_pol_link_if ();
  pol_load_conv i_pol_load_conv (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .link(i_pol_link_if), .OUT_EN_IN(out_en), .VOUT_SET_IN(12'h800),
    .VOUT_ADC_IN(12'h7a5), .IOUT_ADC_IN(8'h3c), .TEMP_ADC_IN(8'h80),
    .PHASE_OUT_OUT(phase_out), .SYNC_LOCK_OUT(sync_lock));
  pol_power_manager #(.REFRESH_CYCLES(50000)) i_pol_power_manager (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .link(i_pol_link_if),
    .REQ_VALID_IN(req_valid), .REQ_WRITE_IN(req_write),
    .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata),
    .REQ_READY_OUT(req_ready), .RSP_VALID_OUT(rsp_valid),
    .RSP_RDATA_OUT(rsp_rdata), .VOUT_COPY_OUT(vout_copy),
    .IOUT_COPY_OUT(iout_copy), .TEMP_COPY_OUT(temp_copy));
  pol_link_assertions u_chk (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .sync_comm_line(i_pol_link_if.sync_comm_line),
    .mgr_dat_out(i_pol_link_if.mgr_dat_out),
    .mgr_dat_oe_n(i_pol_link_if.mgr_dat_oe_n),
    .dev_dat_out(i_pol_link_if.dev_dat_out),
    .dev_dat_oe_n(i_pol_link_if.dev_dat_oe_n),
    .dat(i_pol_link_if.dat));

  task automatic chk(input string nm, input logic [11:0] e, g);
    checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Writes answer with zero data, so every transfer is compared
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [7:0] wd, e);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= wd;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 40000);
    req_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 40000);
    chk($sformatf("addr %h", a), {4'h0, e}, {4'h0, rsp_rdata});
    if (n >= 40000) begin
      chk("timeout", 12'h000, 12'h001);
      report_and_stop();
    end
  endtask

  // Skip two line periods (400 clocks), then collect over four more (800 clocks) which outputs switch
  task automatic obs(input logic [3:0] e);
    repeat (400) @(posedge clk);
    seen = 4'h0;
    repeat (800) begin
      @(posedge clk);
      seen |= phase_out;
    end
    chk("phase outputs", {8'h00, e}, {8'h00, seen});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    xfer(1'b0, ADDR_INTERLEAVE, 8'h00, INTERLEAVE_RST);
    xfer(1'b0, ADDR_DUTY_LIMIT, 8'h00, DUTY_LIMIT_RST);
    chk("lock", 12'h001, {11'h000, sync_lock});
    $display("test reset values done");
    out_en <= 1'b1;
    xfer(1'b1, ADDR_INTERLEAVE, 8'he1, 8'h00);
    xfer(1'b0, ADDR_INTERLEAVE, 8'h00, 8'h00);
    obs(4'h1);
    xfer(1'b1, ADDR_DUTY_LIMIT, 8'h00, 8'h00);
    obs(4'h0);
    $display("test running writes done");
    out_en <= 1'b0;
    xfer(1'b1, ADDR_INTERLEAVE, 8'hff, 8'h00);
    xfer(1'b0, ADDR_INTERLEAVE, 8'h00, 8'hef);
    xfer(1'b1, ADDR_DUTY_LIMIT, 8'hff, 8'h00);
    xfer(1'b0, ADDR_DUTY_LIMIT, 8'h00, 8'hfc);
    for (int k = 0; k < 4; k++) begin
      out_en <= 1'b0;
      xfer(1'b1, ADDR_INTERLEAVE, {k[1:0], 6'h2a}, 8'h00);
      out_en <= 1'b1;
      obs(masks[k]);
    end
    $display("test phase select done");
    xfer(1'b1, ADDR_PROP_COEF, 8'h5c, 8'h00);
    xfer(1'b0, ADDR_PROP_COEF, 8'h00, 8'h5c);
    xfer(1'b0, 5'h1f, 8'h00, 8'h00);
    xfer(1'b1, ADDR_PROBE_CTRL, 8'h01, 8'h00);
    xfer(1'b0, ADDR_PROBE_DATA, 8'h00, 8'h7a);
    chk("vout copy", 12'h7a5, vout_copy);
    chk("iout copy", 12'h030, {4'h0, iout_copy});
    chk("temp copy", 12'h080, {4'h0, temp_copy});
    $display("test coefficients and readings done");
    report_and_stop();
  end
endmodule
